// [rtl/rx_port_pkg.sv]
/*
  shared constants and types for the receive-side ddr pair port:
  register map of the ahb-lite slave, field layout, reset values,
  interface modes and the decoded/undecoded word carrier.
  assumes one 32-bit ahb-lite master and word-aligned accesses.
*/
package rx_port_pkg;

  // register map, byte addresses in the low address byte
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  CTRL_ADDR   = 8'h00;
  localparam logic [7:0]  STATUS_ADDR = 8'h04;

  // control and status field layout
  localparam int unsigned CFG_W       = 4;
  localparam int unsigned ST_W        = 6;
  localparam int unsigned ST_SRC_BIT  = 4;
  localparam int unsigned ST_ACT_BIT  = 5;

  // parallel interface mode; code 2'h3 is illegal
  typedef enum logic [1:0] {
    MODE_NIBBLE,
    MODE_MUX,
    MODE_INDEP
  } mode_e;

  // control word: mode [1:0], decode enable [2], compensation [3]
  typedef struct packed {
    logic  ctc_en;
    logic  code_en;
    mode_e mode;
  } cfg_s;

  localparam cfg_s CFG_RST = '{ctc_en: 1'b1, code_en: 1'b1,
                               mode: MODE_NIBBLE};

  // one received word as handed over by the decoder
  typedef struct packed {
    logic       kchar;
    logic [7:0] data;
    logic [9:0] code;
  } rx_word_s;

  // pair bus layout
  localparam int unsigned BUS_W    = 10;
  localparam int unsigned NIB_W    = 5;
  localparam int unsigned CH_CLK_N = 7;

  // recovered clock divider: the byte clock is one tenth of it
  localparam int unsigned RECOV_DIV = 10;
  localparam logic [2:0]  DIV_LAST  = 3'(RECOV_DIV / 2 - 1);
  localparam logic [2:0]  DIV_ONE   = 3'h1;

endpackage

// [rtl/rx_ddr_parallel_output_port.sv]
/*
  receive-side ddr output of the channel a/b pair bus and the
  receive byte clocks, with an ahb-lite register slave for the
  interface mode, decode enable and compensation enable.
  assumes: clk/rst drive the bus slave; link_clk stands for the
  reference clock and, in nibble mode with compensation off, for the recovered
  clock; the decoder delivers a and b words in link_clk domain.
*/
`timescale 1ns/10ps

module rx_ddr_parallel_output_port (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic                  link_clk,
  input  rx_port_pkg::rx_word_s      chan_a_word,
  input  rx_port_pkg::rx_word_s      chan_b_word,
  output logic                       rx_word_take,
  output logic                       channel_h_rx_clock,
  output logic [6:0]                 per_channel_rx_clocks,
  output logic [7:0]                 pair_ab_rx_data,
  output logic                       pair_ab_rx_bit8_kflag,
  output logic                       pair_ab_rx_bit9
);

  // bus side state
  logic                     hready_reg;
  logic [31:0]              hrdata_reg;
  logic                     wr_pend_reg;
  logic [7:0]               waddr_reg;
  rx_port_pkg::cfg_s        cfg_reg;
  logic [5:0]               st_meta_reg;
  logic [5:0]               st_sync_reg;

  // link side state
  logic                     lk_rst_meta;
  logic                     lk_rst_reg;
  rx_port_pkg::cfg_s        cfg_meta_reg;
  rx_port_pkg::cfg_s        lk_cfg;
  rx_port_pkg::cfg_s        lk_cfg_d;
  logic [2:0]               div_reg;
  logic                     main_reg;
  logic [6:0]               per_reg;
  logic [9:0]               bus_reg;
  rx_port_pkg::rx_word_s    a_hold_reg;
  rx_port_pkg::rx_word_s    b_hold_reg;
  logic                     act_reg;
  logic                     take_reg;
  wire                      src_rec;

  // hsize is accepted but only whole-word transfers are issued
  wire                      size_unused = ^hsize;

  // address phase decode
  wire                      sel_w;
  wire                      rd_ctrl_w;
  wire                      rd_stat_w;
  wire                      wr_ctrl_w;
  wire [3:0]                ctrl_view_w;
  wire [31:0]               rd_word_w;

  assign sel_w     = hsel & hready & htrans[1];
  assign rd_ctrl_w = haddr[7:0] == rx_port_pkg::CTRL_ADDR;
  assign rd_stat_w = haddr[7:0] == rx_port_pkg::STATUS_ADDR;
  assign wr_ctrl_w = wr_pend_reg &
                     (waddr_reg == rx_port_pkg::CTRL_ADDR);

  // a read right behind a write to control sees the new value
  assign ctrl_view_w = wr_ctrl_w ? hwdata[3:0] : cfg_reg;
  assign rd_word_w =
    rd_ctrl_w ? {28'h0000000, ctrl_view_w} :
    rd_stat_w ? {26'h0000000, st_sync_reg} : 32'h00000000;

  // zero-wait slave: data phase always completes, always okay
  always_ff @(posedge clk) begin
    if (rst) begin
      hready_reg  <= 1'b0;
      wr_pend_reg <= 1'b0;
      waddr_reg   <= 8'h00;
      hrdata_reg  <= 32'h00000000;
    end else begin
      hready_reg  <= 1'b1;
      wr_pend_reg <= sel_w & hwrite;
      waddr_reg   <= haddr[7:0];
      hrdata_reg  <= (sel_w & ~hwrite) ? rd_word_w : 32'h00000000;
    end
  end

  // control register; writes elsewhere are dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg <= rx_port_pkg::CFG_RST;
    end else if (wr_ctrl_w) begin
      cfg_reg <= rx_port_pkg::cfg_s'(hwdata[3:0]);
    end
  end

  assign hreadyout = hready_reg;
  assign hresp     = size_unused & 1'b0;
  assign hrdata    = hrdata_reg;

  // link status back to the bus clock; slow levels, two flops
  always_ff @(posedge clk) begin
    if (rst) begin
      st_meta_reg <= 6'h00;
      st_sync_reg <= 6'h00;
    end else begin
      st_meta_reg <= {act_reg, src_rec, lk_cfg};
      st_sync_reg <= st_meta_reg;
    end
  end

  // reset into the link domain, two flops
  always_ff @(posedge link_clk) begin
    lk_rst_meta <= rst;
    lk_rst_reg  <= lk_rst_meta;
  end

  // settings cross as levels; software keeps them still while
  // data flows, so a torn multi-bit sample cannot be used
  always_ff @(posedge link_clk) begin
    if (lk_rst_reg) begin
      cfg_meta_reg <= rx_port_pkg::CFG_RST;
      lk_cfg       <= rx_port_pkg::CFG_RST;
      lk_cfg_d     <= rx_port_pkg::CFG_RST;
    end else begin
      cfg_meta_reg <= cfg_reg;
      lk_cfg       <= cfg_meta_reg;
      lk_cfg_d     <= lk_cfg;
    end
  end

  // clock source: recovered only for nibble with compensation
  // off; every other mode falls back to the reference
  assign src_rec = (lk_cfg.mode == rx_port_pkg::MODE_NIBBLE) &
                   ~lk_cfg.ctc_en;

  // half-period divider; reference source toggles every edge,
  // recovered source every fifth edge, i.e. one tenth
  wire       toggle_w;
  wire [2:0] div_next;
  wire       main_next;
  assign toggle_w  = ~src_rec | (div_reg == rx_port_pkg::DIV_LAST);
  assign div_next  = toggle_w ? 3'h0 : div_reg + rx_port_pkg::DIV_ONE;
  assign main_next = toggle_w ? ~main_reg : main_reg;

  // clock pins: mux mode pairs true and inverted copies, the
  // other modes copy the main clock to every channel
  wire [6:0] per_next;
  assign per_next =
    (lk_cfg.mode == rx_port_pkg::MODE_MUX) ?
      {~main_next, main_next, ~main_next, main_next,
       ~main_next, main_next, ~main_next} :
      {rx_port_pkg::CH_CLK_N{main_next}};

  // a word is taken as the clock falls; the falling half and
  // the following rising half both show that same word
  wire                   take_w;
  rx_port_pkg::rx_word_s a_cur;
  rx_port_pkg::rx_word_s b_cur;
  assign take_w = toggle_w & main_reg;
  assign a_cur  = take_w ? chan_a_word : a_hold_reg;
  assign b_cur  = take_w ? chan_b_word : b_hold_reg;

  // lay one half period of the pair bus out from the two words
  function automatic logic [9:0] pair_bus(
    input rx_port_pkg::cfg_s     c,
    input logic                  rise,
    input rx_port_pkg::rx_word_s a,
    input rx_port_pkg::rx_word_s b
  );
    logic [9:0]            v;
    rx_port_pkg::rx_word_s w;
    v = 10'h000;
    w = rise ? b : a;
    unique case (c.mode)
      rx_port_pkg::MODE_MUX: begin
        // b rides the rising half, a the falling one
        if (c.code_en) begin
          v = {1'b0, w.kchar, w.data};
        end else begin
          v = w.code;
        end
      end
      default: begin
        // nibble layout, also used in independent mode
        if (c.code_en & ~rise) begin
          v[3:0] = a.data[3:0];
          v[8:5] = b.data[3:0];
        end else if (c.code_en) begin
          v[2:0] = a.data[6:4];
          v[3]   = a.kchar;
          v[4]   = a.data[7];
          v[7:5] = b.data[6:4];
          v[8]   = b.kchar;
          v[9]   = b.data[7];
        end else if (~rise) begin
          // low halves first, a low lines, b high lines
          v = {b.code[4:0], a.code[4:0]};
        end else begin
          v = {b.code[9:5], a.code[9:5]};
        end
      end
    endcase
    return v;
  endfunction

  wire [9:0] bus_next;
  assign bus_next = pair_bus(lk_cfg, main_next, a_cur, b_cur);

  // divider and clock pins
  always_ff @(posedge link_clk) begin
    if (lk_rst_reg) begin
      div_reg  <= 3'h0;
      main_reg <= 1'b0;
      per_reg  <= 7'h00;
    end else begin
      div_reg  <= div_next;
      main_reg <= main_next;
      per_reg  <= per_next;
    end
  end

  // data pins change with each clock edge, so both edges
  // carry data, edge-aligned: the partner must sample away from the edge
  always_ff @(posedge link_clk) begin
    if (lk_rst_reg) begin
      bus_reg    <= 10'h000;
      a_hold_reg <= '0;
      b_hold_reg <= '0;
      act_reg    <= 1'b0;
      take_reg   <= 1'b0;
    end else begin
      bus_reg    <= bus_next;
      a_hold_reg <= a_cur;
      b_hold_reg <= b_cur;
      act_reg    <= act_reg ^ take_w;
      take_reg   <= take_w;
    end
  end

  assign channel_h_rx_clock    = main_reg;
  assign per_channel_rx_clocks = per_reg;
  assign pair_ab_rx_data       = bus_reg[7:0];
  assign pair_ab_rx_bit8_kflag = bus_reg[8];
  assign pair_ab_rx_bit9       = bus_reg[9];
  assign rx_word_take          = take_reg;

  // checks below all live in the link domain
  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (lk_rst_reg);

  wire       rec_d = (lk_cfg_d.mode == rx_port_pkg::MODE_NIBBLE) &
                     ~lk_cfg_d.ctc_en;
  wire       mux_d = lk_cfg_d.mode == rx_port_pkg::MODE_MUX;
  wire       nib_d = lk_cfg_d.mode == rx_port_pkg::MODE_NIBBLE;
  wire [9:0] bus_w = {pair_ab_rx_bit9, pair_ab_rx_bit8_kflag,
                      pair_ab_rx_data};

  sequence s_high5;
    channel_h_rx_clock [*5];
  endsequence

  sequence s_low5;
    !channel_h_rx_clock [*5];
  endsequence

  a_rec_tenth: assert property (
    $rose(channel_h_rx_clock) && rec_d && $past(rec_d)
      |-> s_high5 ##1 s_low5)
    else $error("recovered byte clock is not one tenth");

  // the first link edge after reset still shows the reset level
  a_ref_toggle: assert property (
    !rec_d && !$past(lk_rst_reg) |-> $changed(channel_h_rx_clock))
    else $error("reference byte clock did not toggle");

  a_mux_clk_pairs: assert property (
    mux_d |-> per_channel_rx_clocks ==
      {~channel_h_rx_clock, channel_h_rx_clock,
       ~channel_h_rx_clock, channel_h_rx_clock,
       ~channel_h_rx_clock, channel_h_rx_clock,
       ~channel_h_rx_clock})
    else $error("mux mode clock pairs wrong");

  a_chan_clk_copy: assert property (
    !mux_d |-> per_channel_rx_clocks == {7{channel_h_rx_clock}})
    else $error("channel clocks differ from main clock");

  a_mux_b_rise: assert property (
    mux_d && lk_cfg_d.code_en && channel_h_rx_clock
      |-> pair_ab_rx_data == b_hold_reg.data &&
          pair_ab_rx_bit8_kflag == b_hold_reg.kchar)
    else $error("mux rising half does not carry channel b");

  a_mux_a_fall: assert property (
    mux_d && !lk_cfg_d.code_en && !channel_h_rx_clock
      |-> bus_w == a_hold_reg.code)
    else $error("mux falling half does not carry channel a");

  a_nib_low_fall: assert property (
    nib_d && !lk_cfg_d.code_en && !channel_h_rx_clock
      |-> bus_w == {b_hold_reg.code[4:0], a_hold_reg.code[4:0]})
    else $error("nibble falling half is not the low nibbles");

  a_nib_high_rise: assert property (
    nib_d && !lk_cfg_d.code_en && channel_h_rx_clock
      |-> bus_w == {b_hold_reg.code[9:5], a_hold_reg.code[9:5]})
    else $error("nibble rising half is not the high nibbles");

  a_nib_kflags: assert property (
    nib_d && lk_cfg_d.code_en && channel_h_rx_clock
      |-> pair_ab_rx_data[3] == a_hold_reg.kchar &&
          pair_ab_rx_bit8_kflag == b_hold_reg.kchar)
    else $error("nibble k-flags misplaced");

  a_nib_b_bit3: assert property (
    nib_d && lk_cfg_d.code_en && !channel_h_rx_clock
      |-> pair_ab_rx_bit8_kflag == b_hold_reg.data[3])
    else $error("nibble falling line 8 is not b bit 3");

  a_word_per_fall: assert property (
    $fell(channel_h_rx_clock) |-> rx_word_take ##1 !rx_word_take)
    else $error("word not taken once per falling edge");

  // the remaining halves of both layouts; line 9 of decoded rising halves and the nibble rising data lines stay unjudged
  a_mux_a_dec: assert property (
    mux_d && lk_cfg_d.code_en && !channel_h_rx_clock
      |-> bus_w == {1'b0, a_hold_reg.kchar, a_hold_reg.data})
    else $error("mux falling half does not carry channel a flag");

  a_mux_b_code: assert property (
    mux_d && !lk_cfg_d.code_en && channel_h_rx_clock
      |-> bus_w == b_hold_reg.code)
    else $error("mux rising half does not carry channel b code");

  a_nib_low_dec: assert property (
    nib_d && lk_cfg_d.code_en && !channel_h_rx_clock
      |-> bus_w == {1'b0, b_hold_reg.data[3:0],
                    1'b0, a_hold_reg.data[3:0]})
    else $error("nibble falling half is not the low data nibbles");

  // a take marks the falling half, never the rising one
  a_take_on_fall: assert property (
    rx_word_take |-> !channel_h_rx_clock)
    else $error("word taken outside the falling half");

endmodule

// [dv/rx_pair_latch_model.sv]
/*
  model of the protocol device that latches the a/b pair bus.
  assumes edge-aligned ddr data that holds for a whole link cycle.
*/
`timescale 1ns/10ps

module rx_pair_latch_model (
  input  wire logic       link_clk,
  input  wire logic       rx_clk,
  input  wire logic [6:0] ch_clks,
  input  wire logic [9:0] bus,
  output logic            cap_valid,
  output logic [9:0]      cap_fall,
  output logic [9:0]      cap_rise,
  output logic [6:0]      cap_clks,
  output logic [3:0]      half_len
);
  logic       last_m;
  logic [3:0] low_cnt;
  logic [9:0] fall_hold;

  // sample the low half at its last link edge, the high half at its first: edge-aligned data
  // would be missed if taken at the edge itself
  always_ff @(posedge link_clk) begin
    last_m    <= rx_clk;
    cap_valid <= rx_clk && !last_m;
    if (!rx_clk) begin
      fall_hold <= bus;
      low_cnt   <= last_m ? 4'h1 : low_cnt + 4'h1;
    end else if (!last_m) begin
      cap_fall <= fall_hold;
      cap_rise <= bus;
      cap_clks <= ch_clks;
      half_len <= low_cnt;
    end
  end
endmodule

// [dv/rx_ddr_parallel_output_port_bench.sv]
/*
  self-checking bench: ahb-lite register access and word pairs seen
  through the latch model. assumes a zero-wait slave.
*/
`timescale 1ns/10ps

module rx_ddr_parallel_output_port_bench;
  logic                  clk, link_clk, rst, hsel, hwrite, hresp;
  logic [31:0]           haddr, hwdata, hrdata, rd;
  logic [1:0]            htrans;
  logic                  hreadyout, take, main_clk, bit8, bit9;
  logic                  cap_valid, recov, mux;
  logic [6:0]            ch_clks, cap_clks;
  logic [7:0]            data;
  logic [9:0]            cap_fall, cap_rise;
  logic [3:0]            half_len;
  logic [15:0]           seed;
  logic [19:0]           exp_q[$];
  logic [19:0]           e;
  rx_port_pkg::rx_word_s wa, wb, na, nb;
  rx_port_pkg::cfg_s     cfg;
  int                    bad_count, total_checks, n, takes;
  // recovered-clock settings come last: leaving them mid-period
  // would cut a half period short
  localparam logic [3:0] CFGS[8] = '{4'hc, 4'h8, 4'hd, 4'h9, 4'he,
                                     4'h7, 4'h4, 4'h0};

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // link clock offset so its edges never meet the bus clock's
  initial begin
    link_clk = 1'b0;
    #3;
    forever #7.5 link_clk = ~link_clk;
  end

  rx_ddr_parallel_output_port dut_u (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .link_clk(link_clk), .chan_a_word(wa), .chan_b_word(wb),
    .rx_word_take(take), .channel_h_rx_clock(main_clk),
    .per_channel_rx_clocks(ch_clks), .pair_ab_rx_data(data),
    .pair_ab_rx_bit8_kflag(bit8), .pair_ab_rx_bit9(bit9));

  rx_pair_latch_model partner_u (
    .link_clk(link_clk), .rx_clk(main_clk), .ch_clks(ch_clks),
    .bus({bit9, bit8, data}), .cap_valid(cap_valid),
    .cap_fall(cap_fall), .cap_rise(cap_rise), .cap_clks(cap_clks),
    .half_len(half_len));

  task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic rx_port_pkg::rx_word_s rnd_word();
    logic [2:0] hi;
    seed = lfsr(seed);
    hi = seed[2:0];
    seed = lfsr(seed);
    return rx_port_pkg::rx_word_s'({hi, seed});
  endfunction

  // expected {rising half, falling half} of one word pair
  function automatic logic [19:0] exp_pair(rx_port_pkg::cfg_s c,
      rx_port_pkg::rx_word_s a, rx_port_pkg::rx_word_s b);
    if (c.mode == rx_port_pkg::MODE_MUX)
      return c.code_en ? {1'b0, b.kchar, b.data, 1'b0, a.kchar, a.data}
                       : {b.code, a.code};
    if (!c.code_en)
      return {b.code[9:5], a.code[9:5], b.code[4:0], a.code[4:0]};
    return {b.data[7], b.kchar, b.data[6:4], a.data[7], a.kchar,
            a.data[6:4], 1'b0, b.data[3:0], 1'b0, a.data[3:0]};
  endfunction

  // one single-word transfer; address held until ready is seen
  task automatic ahb(logic wr, logic [31:0] a, logic [31:0] wd,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    check(32'(hresp), 32'h0, "response");
  endtask

  // monitor: each captured pair is matched against the oldest note;
  // exactly one word take must fall between two captures
  always @(negedge link_clk) begin
    if (cap_valid === 1'b1) begin
      if (exp_q.size() != 0) begin
        e = exp_q.pop_front();
        check(32'({cap_rise, cap_fall}), 32'(e), "pair");
        check(32'(cap_fall), 32'(e[9:0]), "fall");
        check(32'(cap_rise), 32'(e[19:10]), "rise");
        check(32'(half_len), recov ? 32'h5 : 32'h1, "half");
        check(32'(cap_clks), mux ? 32'h2a : 32'h7f, "lanes");
        check(32'(takes), 32'h1, "takes");
      end
      takes = 0;
    end
    if (take === 1'b1)
      takes++;
  end

  // a hang ends the run as a failure
  initial begin
    #200000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = '0;
    wa = '0;
    wb = '0;
    seed = 16'h0027;
    recov = 1'b0;
    mux = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    do @(posedge clk); while (hreadyout !== 1'b1);
    ahb(1'b0, 32'h0, 32'h0, rd);
    check(rd, 32'h0000000c, "ctrl reset");
    ahb(1'b1, 32'h10, 32'h3, rd);
    ahb(1'b0, 32'h10, 32'h0, rd);
    check(rd, 32'h0, "unmapped");
    ahb(1'b0, 32'h0, 32'h0, rd);
    check(rd, 32'h0000000c, "ctrl kept");
    $display("test registers done");
    // settings change only while no capture is being judged
    foreach (CFGS[i]) begin
      cfg = rx_port_pkg::cfg_s'(CFGS[i]);
      recov = (cfg.mode == rx_port_pkg::MODE_NIBBLE) && !cfg.ctc_en;
      mux = (cfg.mode == rx_port_pkg::MODE_MUX);
      ahb(1'b1, 32'h0, 32'(CFGS[i]), rd);
      ahb(1'b0, 32'h0, 32'h0, rd);
      check(rd, 32'(CFGS[i]), "ctrl");
      repeat (20) @(posedge clk);
      ahb(1'b0, 32'h4, 32'h0, rd);
      check(rd & 32'h1f, {27'h0, recov, CFGS[i]}, "status");
      repeat (4) begin
        na = rnd_word();
        nb = rnd_word();
        @(posedge link_clk);
        wa <= na;
        wb <= nb;
        repeat (30) @(posedge link_clk);
        exp_q.push_back(exp_pair(cfg, na, nb));
        n = 0;
        while (exp_q.size() != 0 && n < 40) begin
          @(posedge link_clk);
          n++;
        end
        check(32'(exp_q.size()), 32'h0, "capture");
        exp_q.delete();
      end
      $display("test cfg %h done", CFGS[i]);
    end
    report_and_stop();
  end
endmodule
